/* tb/eeic_ctrl_assertions.sv */
// eeic_ctrl_assertions: port level checks of the event controller.
// assumes it is bound to eeic_ctrl and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module eeic_ctrl_assertions (
  // clock and reset
  input wire logic                pclk,
  input wire logic                presetn,
  // apb
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [7:0]          paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  // events and outputs
  input wire eeic_pkg::eeic_evt_t evt,
  input wire logic                tx_request,
  input wire logic                irq_n
);
  import eeic_pkg::*;
  logic        wr;
  logic [15:0] en_q;
  assign wr = psel && penable && pready && pwrite;
  // shadow of the mask; per-source pin checks only fire while apb is quiet, a_gie_off fires always
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      en_q <= EEIC_ENABLE_RST;
    else if (wr && paddr == EEIC_OFS_ENABLE)
      en_q <= pwdata[15:0] & EEIC_ENABLE_WMSK | 16'h0010;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_go; en_q[15] && !psel; endsequence
  sequence s_low; ##2 !irq_n; endsequence
  property p_gie_off; !en_q[15] && !$past(en_q[15]) |-> irq_n; endproperty
  a_gie_off: assert property (p_gie_off) else $error("pin low");
  property p_fixed;
    psel && penable && pready && !pwrite && paddr == EEIC_OFS_ENABLE
      |-> prdata[EEIC_B_FIXED];
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed bit");
  property p_modexp; evt.modexp_done && en_q[14] ##0 s_go |-> s_low;
  endproperty
  a_modexp: assert property (p_modexp) else $error("modexp");
  property p_hash; evt.hash_done && en_q[13] ##0 s_go |-> s_low; endproperty
  a_hash: assert property (p_hash) else $error("hash");
  property p_cipher; evt.cipher_done && en_q[12] ##0 s_go |-> s_low;
  endproperty
  a_cipher: assert property (p_cipher) else $error("cipher");
  property p_link; $changed(evt.link_up) && en_q[11] ##0 s_go
    |-> ##[2:3] !irq_n; endproperty
  a_link: assert property (p_link) else $error("link");
  property p_dma; evt.dma_done && en_q[5] ##0 s_go |-> s_low; endproperty
  a_dma: assert property (p_dma) else $error("dma");
  property p_txdone; evt.tx_ok && tx_request && en_q[3] ##0 s_go |-> s_low;
  endproperty
  a_txdone: assert property (p_txdone) else $error("tx done");
  property p_txabort; wr && paddr == EEIC_OFS_CTRL && !pwdata[EEIC_B_TXREQ]
    && tx_request |=> !tx_request; endproperty
  a_txabort: assert property (p_txabort) else $error("tx abort");
endmodule
`default_nettype wire

/* tb/eeic_ctrl_test.sv */
// eeic_ctrl_test: apb driven checks of the event interrupt controller.
// assumes one wait state apb slave and one-cycle event pulses.
`timescale 1ns/1ps
`default_nettype none
module eeic_ctrl_test;
  import eeic_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        tx_request, irq_n, rerr, link;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  eeic_evt_t   evt, e;
  int          n_fail, num_checks, wakes, n0;
  int          srcs [6] = '{14, 13, 12, 5, 11, 3};
  eeic_ctrl i_eeic_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .evt(evt),
    .tx_request(tx_request), .irq_n(irq_n));
  eeic_host_model i_eeic_host_model (.pclk(pclk), .presetn(presetn),
    .irq_n(irq_n), .wakes(wakes));
  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end
  task automatic cmp(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic pin(input logic g, input logic x);
    num_checks++;
    if (g !== x) begin
      n_fail++;
      $display("CHECK FAILED %0t pin %b exp %b", $time, g, x);
    end
  endtask
  // the idle edge at the end keeps two requests from sharing a step
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, x);
    acc(1'h0, a, 32'h0);
    cmp(rdat & m, x);
  endtask
  task automatic rf(input logic [31:0] m, x);
    rd(EEIC_OFS_FLAG, m, x);
  endtask
  task automatic ev(input eeic_evt_t v);
    eeic_evt_t z;
    z = '0;
    z.link_up = link;
    v.link_up = link;
    evt <= v;
    @(posedge pclk);
    evt <= z;
    @(posedge pclk);
  endtask
  task automatic fire(input int b);
    e = '0;
    case (b)
      14: e.modexp_done = 1'h1;
      13: e.hash_done = 1'h1;
      12: e.cipher_done = 1'h1;
      5: e.dma_done = 1'h1;
      11: link = ~link;
      default: begin
        e.tx_start = 1'h1;
        ev(e);
        e = '0;
        e.tx_ok = 1'h1;
      end
    endcase
    ev(e);
  endtask
  task automatic tx(input int n, input logic [15:0] by, input logic df);
    e = '0;
    e.tx_start = 1'h1;
    ev(e);
    e = '0;
    e.tx_defer = df;
    if (df) ev(e);
    e.tx_collision = 1'h1;
    e.tx_bytes = by;
    repeat (n) ev(e);
  endtask
  task automatic ab(input logic [31:0] m, x);
    rf(32'h4, 32'h4);
    rd(EEIC_OFS_TXSTAT, m, x);
    acc(1'h1, EEIC_OFS_FLAG_CLR, 32'h4);
  endtask
  task automatic end_sim;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    end_sim;
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata, evt, link} = '0;
    presetn = 1'h0;
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    rd(EEIC_OFS_ENABLE, 32'hffff, 32'h8010);
    acc(1'h1, EEIC_OFS_ENABLE, 32'h0);
    rd(EEIC_OFS_ENABLE, 32'hffff, 32'h10);
    rd(8'h1c, 32'hffffffff, 32'h0);
    pin(rerr, 1'h1);
    foreach (srcs[i]) begin
      for (int k = 0; k < 2; k++) begin
        acc(1'h1, EEIC_OFS_ENABLE, k ? 32'h8000 | 32'h1 << srcs[i] : 0);
        fire(srcs[i]);
        rf(32'h1 << srcs[i], 32'h1 << srcs[i]);
        rd(EEIC_OFS_STATUS, 32'h100, {23'h0, link, 8'h0});
        repeat (3) @(posedge pclk);
        pin(irq_n, k == 0);
        if (k) begin
          acc(1'h1, EEIC_OFS_ENABLE, 32'h1 << srcs[i]);
          repeat (3) @(posedge pclk);
          pin(irq_n, 1'h1);
        end
        acc(1'h1, EEIC_OFS_FLAG_CLR, 32'h1 << srcs[i]);
        rf(32'hffff, 32'h0);
      end
    end
    e = '0;
    e.dma_done = 1'h1;
    fork
      acc(1'h1, EEIC_OFS_FLAG_CLR, 32'h20);
      begin
        repeat (2) @(posedge pclk);
        ev(e);
      end
    join
    rf(32'h20, 32'h20);
    acc(1'h1, EEIC_OFS_FLAG_CLR, 32'h20);
    acc(1'h1, EEIC_OFS_CTRL, 32'h2);
    tx(2, 16'h0, 1'h0);
    pin(tx_request, 1'h1);
    ev(e);
    ab(32'hf, 32'h3);
    acc(1'h1, EEIC_OFS_CTRL, 32'hf);
    tx(1, 16'h3f, 1'h0);
    pin(tx_request, 1'h1);
    e.tx_bytes = 16'h40;
    ev(e);
    ab(32'h400, 32'h400);
    tx(0, 16'h0, 1'h1);
    ab(32'h100, 32'h100);
    tx(0, 16'h0, 1'h0);
    acc(1'h1, EEIC_OFS_CTRL, 32'hd);
    pin(tx_request, 1'h0);
    ab(32'h50f, 32'h0);
    acc(1'h1, EEIC_OFS_ENABLE, 32'h8040);
    e = '0;
    e.rx_frame = 1'h1;
    ev(e);
    rf(32'h43, 32'h0);
    n0 = wakes;
    e.rx_accept = 1'h1;
    ev(e);
    repeat (3) @(posedge pclk);
    cmp(wakes, n0 + 1);
    rd(EEIC_OFS_STATUS, 32'h80ff, 32'h8001);
    rf(32'h40, 32'h40);
    e.rx_no_room = 1'h1;
    ev(e);
    rf(32'h43, 32'h42);
    rd(EEIC_OFS_STATUS, 32'hff, 32'h1);
    acc(1'h1, EEIC_OFS_FLAG_CLR, 32'h2);
    e.rx_no_room = 1'h0;
    repeat (254) ev(e);
    rf(32'h43, 32'h41);
    ev(e);
    rf(32'h43, 32'h43);
    rd(EEIC_OFS_STATUS, 32'hff, 32'hff);
    e = '0;
    e.pkt_dec = 1'h1;
    ev(e);
    rf(32'h1, 32'h0);
    repeat (254) ev(e);
    rf(32'h40, 32'h0);
    end_sim;
  end
endmodule
bind eeic_ctrl eeic_ctrl_assertions i_eeic_ctrl_assertions (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .evt(evt), .tx_request(tx_request), .irq_n(irq_n));
`default_nettype wire

/* tb/eeic_host_model.sv */
// eeic_host_model: host that sleeps and wakes on a falling pin.
// assumes irq_n is the registered active low pin.
`timescale 1ns/1ps
`default_nettype none
module eeic_host_model (
  // clock and pin
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic irq_n,
  // wake-ups seen
  output var int    wakes
);
  logic irq_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'h1;
      wakes <= 0;
    end else begin
      irq_q <= irq_n;
      if (irq_q && !irq_n)
        wakes <= wakes + 1;
    end
  end
endmodule
`default_nettype wire

/* verilog/eeic_apb_slave.sv */
// eeic_apb_slave: apb decode, one access with one wait state per transfer.
// assumes the master holds request fields through the access phase.
`timescale 1ns/1ps
`default_nettype none
module eeic_apb_slave (
  // apb
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  // decoded strobes
  output logic             wr_stb,
  output logic             rd_stb,
  output logic [7:0]       reg_ofs
);
  assign wr_stb  = psel & penable & pwrite;
  assign rd_stb  = psel & penable & ~pwrite;
  assign reg_ofs = {paddr[7:2], 2'b00};
endmodule
`default_nettype wire

/* verilog/eeic_ctrl.sv */
// Notes on behaviour
// - frame dropped for lack of room or saturated counter sets rx abort
// - counter at maximum sets counter full, cleared once it decrements
// - with global enable set the pin follows summary, else high
// - enable bit 4 reads one, cannot be written or changed
// - no source reaches the pin without the global enable
// - modexp start clearing sets modexp flag, enable bit 14
// - hash engine completion sets hash flag, enable bit 13
// - cipher start clearing sets cipher flag, enable bit 12
// - link up or down sets link flag; live state in status bit 8
// - packet pending flag is read-only, high while count non-zero
// - dma start clearing sets dma flag, enable bit 5
// - tx request clearing at frame end sets tx done, enable bit 3
// - collisions past retry limit abort tx, count in txstat 3:0
// - collision after 63 bytes aborts tx and sets late bit 10
// - excess deferral aborts tx and sets txstat bit 8
// - software clearing tx request mid frame aborts, enable bit 2
// - head overrunning tail or full counter drops frame, enable bit 1
// - filter rejects never set rx abort
// - accepted wake frame bumps the counter, pulling the pin low if enabled
// - enabled flag plus global enable drives pin low, sets summary
// - flags set even when their enable is clear
//
// eeic_ctrl: top of the event interrupt controller.
// assumes engines pulse one-cycle done events and the receive path
// has already applied its filters before raising rx_frame.
//
// Design decisions made here: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module eeic_ctrl (
  // clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // apb
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  // engine events
  input  wire eeic_pkg::eeic_evt_t evt,
  // control outputs
  output logic                     tx_request,
  output logic                     irq_n
);
  import eeic_pkg::*;

  typedef struct packed {
    eeic_state_t st;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
    logic        irq_n;
  } eeic_top_t;

  eeic_top_t q;
  eeic_top_t d;

  logic       wr_stb;
  logic       rd_stb;
  logic [7:0] reg_ofs;
  logic       summary;
  logic       pin_low;

  eeic_apb_slave i_eeic_apb_slave (
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .paddr   (paddr),
    .wr_stb  (wr_stb),
    .rd_stb  (rd_stb),
    .reg_ofs (reg_ofs)
  );

  eeic_irq_gate i_eeic_irq_gate (
    .flags   (q.st.flags),
    .enable  (q.st.enable),
    .summary (summary),
    .pin_low (pin_low)
  );

  function automatic logic known_ofs(input logic [7:0] o);
    known_ofs = (o == EEIC_OFS_ENABLE) || (o == EEIC_OFS_FLAG) ||
                (o == EEIC_OFS_FLAG_SET) || (o == EEIC_OFS_FLAG_CLR) ||
                (o == EEIC_OFS_STATUS) || (o == EEIC_OFS_TXSTAT) ||
                (o == EEIC_OFS_CTRL);
  endfunction

  logic [15:0] hw_set;
  logic [15:0] sw_set;
  logic [15:0] sw_clr;
  logic        wr_ack;
  logic        drop;
  logic        sw_abort;
  logic        tx_end;
  logic        tx_abort_ev;
  logic        coll_over;
  logic        late_ev;
  logic [3:0]  coll_next;
  logic [15:0] wdat;

  always_comb begin
    d = q;
    hw_set = 16'h0000;
    sw_set = 16'h0000;
    sw_clr = 16'h0000;
    wdat = pwdata[15:0];
    // writes land at the edge that completes the transfer
    wr_ack = wr_stb & q.ready;
    d.ready = (wr_stb | rd_stb) & ~q.ready;
    d.err = (wr_stb | rd_stb) & ~q.ready & ~known_ofs(reg_ofs);
    d.rdata = 32'h0000_0000;

    // dropped frames: no room or counter saturated; filter rejects
    // never arrive here as rx_frame
    drop = evt.rx_frame &
           (evt.rx_no_room | (q.st.count == EEIC_CNT_MAX));
    hw_set[EEIC_B_RXABORT] = drop;
    if (evt.rx_frame && evt.rx_accept && !drop) begin
      d.st.count = q.st.count + 8'h01;
    end
    if (evt.pkt_dec && q.st.count != 8'h00) begin
      d.st.count = d.st.count - 8'h01;
    end

    hw_set[EEIC_B_MODEXP] = evt.modexp_done;
    hw_set[EEIC_B_HASH]   = evt.hash_done;
    hw_set[EEIC_B_CIPHER] = evt.cipher_done;
    hw_set[EEIC_B_DMA]    = evt.dma_done;
    d.st.link_q = evt.link_up;
    hw_set[EEIC_B_LINK] = evt.link_up ^ q.st.link_q;

    // transmit path
    sw_abort = 1'b0;
    coll_next = q.st.coll;
    coll_over = 1'b0;
    late_ev = 1'b0;
    if (evt.tx_start && !q.st.tx_busy) begin
      d.st.tx_busy = 1'b1;
      d.st.coll = 4'h0;
      d.st.late = 1'b0;
      d.st.defer = 1'b0;
    end
    if (q.st.tx_busy && evt.tx_collision) begin
      late_ev = (evt.tx_bytes > 16'(EEIC_LATE_BYTES));
      // the collision that exceeds the limit is still counted, saturating at 15
      coll_over = (q.st.coll >= q.st.retry_limit);
      if (q.st.coll != 4'hf) begin
        coll_next = q.st.coll + 4'h1;
      end
      d.st.coll = coll_next;
    end
    if (wr_ack && reg_ofs == EEIC_OFS_CTRL) begin
      d.st.retry_limit = wdat[3:0];
      if (!wdat[EEIC_B_TXREQ] && q.st.tx_busy) begin
        sw_abort = 1'b1;
      end
    end
    tx_abort_ev = q.st.tx_busy &
                  (late_ev | coll_over | evt.tx_defer | sw_abort);
    tx_end = q.st.tx_busy & (evt.tx_ok | tx_abort_ev);
    if (late_ev) begin
      d.st.late = 1'b1;
    end
    if (q.st.tx_busy && evt.tx_defer) begin
      d.st.defer = 1'b1;
    end
    if (tx_end) begin
      d.st.tx_busy = 1'b0;
    end
    hw_set[EEIC_B_TXDONE]  = tx_end;
    hw_set[EEIC_B_TXABORT] = tx_abort_ev;

    // register writes
    if (wr_ack) begin
      unique case (reg_ofs)
        EEIC_OFS_ENABLE:
          d.st.enable = wdat & EEIC_ENABLE_WMSK;
        EEIC_OFS_FLAG: begin
          sw_set = wdat & EEIC_FLAG_SWMSK;
          sw_clr = ~wdat & EEIC_FLAG_SWMSK;
        end
        EEIC_OFS_FLAG_SET:
          sw_set = wdat & EEIC_FLAG_SWMSK;
        EEIC_OFS_FLAG_CLR:
          sw_clr = wdat & EEIC_FLAG_SWMSK;
        default: ;
      endcase
    end
    // fixed enable bit always one, never written or altered
    d.st.enable[EEIC_B_FIXED] = 1'b1;

    // hardware set beats software clear; flags set regardless of enable
    d.st.flags = ((q.st.flags & ~sw_clr) | sw_set | hw_set)
                 & EEIC_FLAG_SWMSK;
    d.st.flags[EEIC_B_PKT] = (d.st.count != 8'h00);
    d.st.flags[EEIC_B_CNTFULL] = (d.st.count == EEIC_CNT_MAX);

    // reads
    if (rd_stb && !q.ready) begin
      unique case (reg_ofs)
        EEIC_OFS_ENABLE:   d.rdata = {16'h0000, q.st.enable};
        EEIC_OFS_FLAG,
        EEIC_OFS_FLAG_SET,
        EEIC_OFS_FLAG_CLR: d.rdata = {16'h0000, q.st.flags};
        EEIC_OFS_STATUS:   d.rdata = {16'h0000, summary, 6'h00,
                                      q.st.link_q, q.st.count};
        EEIC_OFS_TXSTAT:   d.rdata = {21'h0, q.st.late, 1'b0,
                                      q.st.defer, 4'h0, q.st.coll};
        EEIC_OFS_CTRL:     d.rdata = {30'h0, q.st.tx_busy,
                                      1'b0} | {28'h0000000,
                                      q.st.retry_limit} & 32'h0000000d;
        default:           d.rdata = 32'h0000_0000;
      endcase
    end

    // registered pin: one cycle after the flag it reflects
    d.irq_n = ~pin_low;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.st.enable <= EEIC_ENABLE_RST;
      q.st.retry_limit <= EEIC_RETRY_RST;
      q.irq_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign prdata     = q.rdata;
  assign pready     = q.ready;
  assign pslverr    = q.err;
  assign tx_request = q.st.tx_busy;
  assign irq_n      = q.irq_n;
endmodule
`default_nettype wire

/* verilog/eeic_irq_gate.sv */
// eeic_irq_gate: combines flags, enables and the global enable.
// assumes flags and enables are registered upstream.
`timescale 1ns/1ps
`default_nettype none
module eeic_irq_gate (
  // state
  input  wire logic [15:0] flags,
  input  wire logic [15:0] enable,
  // result
  output logic             summary,
  output logic             pin_low
);
  import eeic_pkg::*;
  logic [15:0] src;
  // bit 15 of the flag word is not an event, exclude it
  assign src     = flags & enable & 16'h7fff & ~(16'h1 << EEIC_B_FIXED);
  assign summary = |src;
  assign pin_low = summary & enable[EEIC_B_GLOBAL];
endmodule
`default_nettype wire

/* verilog/eeic_pkg.sv */
// eeic_pkg: register map, field positions and carrier types of the
// ethernet event interrupt controller.
// assumes a 32-bit apb slave with word aligned registers.
package eeic_pkg;
  localparam logic [7:0]  EEIC_OFS_ENABLE   = 8'h00;
  localparam logic [7:0]  EEIC_OFS_FLAG     = 8'h04;
  localparam logic [7:0]  EEIC_OFS_FLAG_SET = 8'h08;
  localparam logic [7:0]  EEIC_OFS_FLAG_CLR = 8'h0c;
  localparam logic [7:0]  EEIC_OFS_STATUS   = 8'h10;
  localparam logic [7:0]  EEIC_OFS_TXSTAT   = 8'h14;
  localparam logic [7:0]  EEIC_OFS_CTRL     = 8'h18;

  localparam int EEIC_B_GLOBAL  = 15;
  localparam int EEIC_B_MODEXP  = 14;
  localparam int EEIC_B_HASH    = 13;
  localparam int EEIC_B_CIPHER  = 12;
  localparam int EEIC_B_LINK    = 11;
  localparam int EEIC_B_PKT     = 6;
  localparam int EEIC_B_DMA     = 5;
  localparam int EEIC_B_FIXED   = 4;
  localparam int EEIC_B_TXDONE  = 3;
  localparam int EEIC_B_TXABORT = 2;
  localparam int EEIC_B_RXABORT = 1;
  localparam int EEIC_B_CNTFULL = 0;
  localparam int EEIC_B_SUMMARY = 15;
  localparam int EEIC_B_LINKUP  = 8;
  localparam int EEIC_B_LATE    = 10;
  localparam int EEIC_B_DEFER   = 8;
  localparam int EEIC_B_TXREQ   = 1;

  localparam logic [15:0] EEIC_ENABLE_RST  = 16'h8010;
  localparam logic [15:0] EEIC_ENABLE_WMSK = 16'hf86f;
  localparam logic [15:0] EEIC_FLAG_SWMSK  = 16'hf82f;
  localparam logic [7:0]  EEIC_CNT_MAX     = 8'hff;
  localparam logic [3:0]  EEIC_RETRY_RST   = 4'hf;
  localparam int          EEIC_LATE_BYTES  = 63;

  typedef struct packed {
    logic modexp_done;
    logic hash_done;
    logic cipher_done;
    logic dma_done;
    logic link_up;
    logic rx_frame;
    logic rx_accept;
    logic rx_no_room;
    logic tx_start;
    logic tx_ok;
    logic tx_collision;
    logic tx_defer;
    logic [15:0] tx_bytes;
    logic pkt_dec;
  } eeic_evt_t;

  typedef struct packed {
    logic [15:0] enable;
    logic [15:0] flags;
    logic [7:0]  count;
    logic [3:0]  coll;
    logic        late;
    logic        defer;
    logic        tx_busy;
    logic        link_q;
    logic [3:0]  retry_limit;
  } eeic_state_t;
endpackage
